// ===== char_lcd_host.sv
// Host controller driving the display bus: polls busy, splits nibbles,
// inserts a dummy read before a data read when no address set or data read came since the last data write or reset.
// Software reaches it over a plain strobe port, read data one cycle later.
`default_nettype none
module char_lcd_host (
	// Clock, reset, enable
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	// Software port
	input wire logic [4:0] addr_i,
	input wire logic [31:0] wdata_i,
	input wire logic we_i,
	input wire logic re_i,
	output logic [31:0] rdata_o,
	// Display bus
	lcd_bus_if.host bus
);
	typedef enum logic [1:0] {ST_IDLE, ST_STROBE, ST_CAPTURE} host_st_type;
	typedef struct packed {
		host_st_type st;
		logic polling;
		logic dummy;
		logic nib;
		logic four;
		logic page;
		logic fresh;
		logic rs;
		logic rw;
		logic [7:0] tx;
		logic [7:0] rx;
		logic [7:0] rx_data;
		logic [31:0] rdata;
	} state_type;

	state_type s_r, s_nxt;
	logic [7:0] fixed;
	localparam int XFER_RS = lcd_pkg::XFER_RS_BIT;
	logic bus_rw;
	logic [7:0] out_byte;

	always_comb begin
		s_nxt = s_r;
		fixed = wdata_i[7:0];
		if (~wdata_i[XFER_RS] & (fixed[7:5] == 3'b001)) begin
			fixed[1] = 1'b0; // RULE23
			if (fixed[3]) begin
				fixed[2] = 1'b0; // RULE11
			end
		end
		s_nxt.rdata = 32'h0;
		if (re_i) begin
			if (addr_i == lcd_pkg::REG_STATUS) begin
				s_nxt.rdata = {29'h0, s_r.page, s_r.four, s_r.st != ST_IDLE};
			end else if (addr_i == lcd_pkg::REG_RX_DATA) begin
				s_nxt.rdata = {24'h0, s_r.rx_data};
			end
		end
		unique case (s_r.st)
			ST_IDLE: begin
				// Requests while a transfer runs are dropped
				if (we_i & ((addr_i == lcd_pkg::REG_WRITE_XFER) |
						(addr_i == lcd_pkg::REG_READ_XFER))) begin
					s_nxt.rs = wdata_i[XFER_RS];
					s_nxt.rw = (addr_i == lcd_pkg::REG_READ_XFER);
					s_nxt.tx = fixed;
					s_nxt.polling = 1'b1; // RULE17
					s_nxt.dummy = (addr_i == lcd_pkg::REG_READ_XFER) & wdata_i[XFER_RS]
						& ~s_r.fresh; // RULE20
					s_nxt.st = ST_STROBE;
				end
			end
			ST_STROBE: begin
				s_nxt.st = ST_CAPTURE;
			end
			ST_CAPTURE: begin
				if (bus_rw) begin
					if (~s_r.four) begin
						s_nxt.rx = bus.d;
					end else if (~s_r.nib) begin
						s_nxt.rx[7:4] = bus.d[7:4]; // RULE24
					end else begin
						s_nxt.rx[3:0] = bus.d[7:4];
					end
				end
				if (s_r.four & ~s_r.nib) begin
					s_nxt.nib = 1'b1; // RULE10
					s_nxt.st = ST_STROBE;
				end else begin
					s_nxt.nib = 1'b0;
					s_nxt.st = ST_STROBE;
					if (s_r.polling) begin
						s_nxt.polling = s_nxt.rx[7]; // RULE17
					end else if (s_r.dummy) begin
						s_nxt.dummy = 1'b0;
						s_nxt.polling = 1'b1;
					end else begin
						s_nxt.st = ST_IDLE;
						if (s_r.rw) begin
							s_nxt.rx_data = s_nxt.rx;
						end
						if (~s_r.rs & ~s_r.rw) begin
							if (s_r.tx[7] | (s_r.tx[7:6] == 2'b01)) begin
								s_nxt.fresh = 1'b1; // RULE22
							end else if (s_r.tx[7:5] == 3'b001) begin
								s_nxt.four = ~s_r.tx[4]; // RULE10
								s_nxt.page = s_r.tx[0];
							end
						end else if (s_r.rs & ~s_r.rw) begin
							s_nxt.fresh = 1'b0;
						end else if (s_r.rs) begin
							s_nxt.fresh = 1'b1;
						end
					end
				end
			end
		endcase
	end

	assign bus_rw = s_r.polling | s_r.rw;
	assign out_byte = s_r.four ? (s_r.nib ? {s_r.tx[3:0], 4'h0} : {s_r.tx[7:4], 4'h0})
		: s_r.tx; // RULE24
	assign bus.strobe = (s_r.st == ST_STROBE);
	assign bus.reg_select_line = ~s_r.polling & s_r.rs;
	assign bus.read_not_write = bus_rw;
	assign bus.host_d = out_byte;
	assign bus.host_d_oe = (s_r.st == ST_STROBE) & ~bus_rw;
	assign rdata_o = s_r.rdata;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s_r <= '0;
			s_r.st <= ST_IDLE;
		end else if (ce_i) begin
			s_r <= s_nxt;
		end
	end
endmodule
`default_nettype wire

// ===== char_lcd_instruction_engine.sv
// Instruction engine of the character display: decodes bus transfers,
// keeps the address counter, display RAMs and display control state.
// Assumes the host shares clk_i and waits while op_in_progress is high.
// Contract
// RULE1: clear fills spaces, homes counter, forces increment
// RULE2: home zeroes counter and display shift
// RULE3: entry direction steps counter up or down
// RULE4: display write with follow-shift shifts display
// RULE5: display-enable blanks panel, keeps RAM
// RULE6: cursor-visible bit shows or hides cursor
// RULE7: blink alternates full cell and character
// RULE8: shift command moves cursor or display
// RULE9: two-line cursor wraps after fortieth position
// RULE10: bus width bit picks 8 or 4 bits
// RULE11: tall font only in one-line mode
// RULE12: option strap high forces normal font
// RULE13: table-page bit selects extension decode page
// RULE14: glyph address set loads six bits
// RULE15: display address set loads seven bits
// RULE16: display address ranges per line mode
// RULE17: status read returns busy and counter
// RULE18: counter steps after each data access
// RULE19: data byte targets last selected RAM
// RULE20: unaddressed first read returns stale byte
// RULE21: bias bit ignored with external resistors
// RULE22: symbol address set loads four bits
// RULE23: host writes zero to test bit
// RULE24: upper nibble travels first on upper lines
//
// The address map and strobed register access are this design's own decisions.
`default_nettype none
module char_lcd_instruction_engine #(
	parameter int LONG_CYCLES = lcd_pkg::LONG_OP_CYCLES,
	parameter int BLINK_HALF_CYCLES = lcd_pkg::BLINK_CYCLES
) (
	// Clock, reset, enable
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	// Host bus
	lcd_bus_if.device bus,
	// Strap pins
	input wire logic option_set_strap_i,
	input wire logic follower_strap_a_i,
	input wire logic follower_strap_b_i,
	// Panel side
	input wire logic [6:0] scan_addr_i,
	output logic [7:0] scan_char_o,
	output logic display_on_o,
	output logic cursor_on_o,
	output logic blink_full_o,
	output logic [6:0] cursor_addr_o,
	output logic [5:0] display_shift_o,
	output logic two_line_o,
	output logic tall_font_o,
	output logic quarter_bias_o,
	output logic op_in_progress_o
);
	typedef struct packed {
		logic [6:0] address_counter;
		lcd_pkg::ram_sel_type ram_sel;
		logic inc;
		logic follow_shift;
		logic disp_on;
		logic cursor_on;
		logic blink_on;
		logic bus_width_select;
		logic two_line;
		logic tall_font_select;
		logic table_page_select;
		logic bias_ratio_select;
		logic [5:0] shift;
		logic [lcd_pkg::BUSY_W-1:0] busy_cnt;
		logic clearing;
		logic [6:0] clr_idx;
		logic nib;
		logic [3:0] wr_hi;
		logic [7:0] rd_hold;
		logic [7:0] rd_latch;
		logic prefetch;
		logic [7:0] dev_d;
		logic dev_d_oe;
		logic [lcd_pkg::BLINK_W-1:0] blink_cnt;
		logic blink_phase;
		logic [2:0] strap_meta;
		logic [2:0] strap_sync;
		logic [7:0] scan_char;
	} state_type;

	state_type s_r, s_nxt;
	logic [7:0] char_display_ram [0:127];
	logic [7:0] glyph_pattern_ram [0:63];
	logic [7:0] symbol_ram [0:15];
	logic mem_we;
	lcd_pkg::ram_sel_type mem_sel;
	logic [6:0] mem_addr;
	logic [7:0] mem_data;
	logic [7:0] rd_mem;
	logic tall;
	logic busy;
	logic four;
	logic byte_done;
	logic [7:0] in_byte;
	logic [7:0] rd_val;

	// Next counter value for one step in the given direction
	function automatic logic [6:0] step_ac(input logic [6:0] ac, input logic up,
			input lcd_pkg::ram_sel_type sel, input logic two, input logic tall_f);
		logic [6:0] lim;
		lim = tall_f ? lcd_pkg::DD_LINE1_END : lcd_pkg::DD_ONE_LINE_END; // RULE11
		if (sel == lcd_pkg::RAM_GLYPH) begin
			return {1'b0, 6'(up ? ac[5:0] + 6'h01 : ac[5:0] - 6'h01)};
		end else if (sel == lcd_pkg::RAM_SYMBOL) begin
			return {3'b000, 4'(up ? ac[3:0] + 4'h1 : ac[3:0] - 4'h1)};
		end else if (two) begin
			// Line one ends at its fortieth cell, then line two begins
			if (up) begin
				return (ac == lcd_pkg::DD_LINE1_END) ? lcd_pkg::DD_LINE2_START : // RULE9
					(ac == lcd_pkg::DD_LINE2_END) ? lcd_pkg::AC_HOME : 7'(ac + 7'h01); // RULE16
			end
			return (ac == lcd_pkg::AC_HOME) ? lcd_pkg::DD_LINE2_END :
				(ac == lcd_pkg::DD_LINE2_START) ? lcd_pkg::DD_LINE1_END : 7'(ac - 7'h01);
		end else if (up) begin
			return (ac >= lim) ? lcd_pkg::AC_HOME : 7'(ac + 7'h01); // RULE16
		end
		return (ac == lcd_pkg::AC_HOME) ? lim : 7'(ac - 7'h01);
	endfunction

	// Display shift by one column, wrapping within SHIFT_SPAN (40) columns in every line mode
	function automatic logic [5:0] shift_by(input logic [5:0] sh, input logic left);
		if (left) begin
			return (sh == 6'(lcd_pkg::SHIFT_SPAN - 6'h01)) ? 6'h00 : 6'(sh + 6'h01);
		end
		return (sh == 6'h00) ? 6'(lcd_pkg::SHIFT_SPAN - 6'h01) : 6'(sh - 6'h01);
	endfunction

	always_comb begin
		unique case (s_r.ram_sel)
			lcd_pkg::RAM_GLYPH: rd_mem = glyph_pattern_ram[s_r.address_counter[5:0]];
			lcd_pkg::RAM_SYMBOL: rd_mem = symbol_ram[s_r.address_counter[3:0]];
			default: rd_mem = char_display_ram[s_r.address_counter];
		endcase
	end

	always_comb begin
		s_nxt = s_r;
		mem_we = 1'b0;
		mem_sel = s_r.ram_sel;
		mem_addr = s_r.address_counter;
		mem_data = 8'h00;
		tall = s_r.tall_font_select & ~s_r.two_line & ~s_r.strap_sync[0]; // RULE12
		busy = (s_r.busy_cnt != '0);
		four = ~s_r.bus_width_select; // RULE10
		byte_done = ~four | s_r.nib;
		in_byte = four ? {s_r.wr_hi, bus.d[7:4]} : bus.d; // RULE24
		rd_val = bus.reg_select_line ? s_r.rd_latch
			: {busy, s_r.address_counter}; // RULE17
		s_nxt.strap_meta = {follower_strap_b_i, follower_strap_a_i, option_set_strap_i};
		s_nxt.strap_sync = s_r.strap_meta;
		s_nxt.scan_char = char_display_ram[scan_addr_i];
		s_nxt.dev_d_oe = 1'b0;
		if (s_r.blink_cnt == '0) begin
			s_nxt.blink_cnt = lcd_pkg::BLINK_W'(BLINK_HALF_CYCLES - 1);
			s_nxt.blink_phase = ~s_r.blink_phase;
		end else begin
			s_nxt.blink_cnt = s_r.blink_cnt - 1'b1;
		end
		if (busy) begin
			s_nxt.busy_cnt = s_r.busy_cnt - 1'b1;
		end
		// Clear walks every display cell while busy keeps the host out
		if (s_r.clearing) begin
			mem_we = 1'b1;
			mem_sel = lcd_pkg::RAM_DISPLAY;
			mem_addr = s_r.clr_idx;
			mem_data = lcd_pkg::SPACE_CODE; // RULE1
			s_nxt.clr_idx = 7'(s_r.clr_idx + 7'h01);
			s_nxt.clearing = (s_r.clr_idx != 7'h7f);
		end
		// Latch refills only after address set or read; a write leaves it stale
		if (s_r.prefetch) begin
			s_nxt.rd_latch = rd_mem; // RULE20
			s_nxt.prefetch = 1'b0;
		end
		if (bus.strobe) begin
			s_nxt.nib = four & ~s_r.nib;
			if (four & ~s_r.nib) begin
				s_nxt.wr_hi = bus.d[7:4];
			end
			if (bus.read_not_write) begin
				s_nxt.dev_d_oe = 1'b1;
				if (~four) begin
					s_nxt.dev_d = rd_val;
				end else if (~s_r.nib) begin
					s_nxt.rd_hold = rd_val;
					s_nxt.dev_d = {rd_val[7:4], 4'h0}; // RULE24
				end else begin
					s_nxt.dev_d = {s_r.rd_hold[3:0], 4'h0};
				end
			end
			if (byte_done & ~busy & bus.reg_select_line) begin
				s_nxt.busy_cnt = lcd_pkg::BUSY_W'(lcd_pkg::SHORT_OP_CYCLES);
				s_nxt.address_counter = step_ac(s_r.address_counter, s_r.inc, s_r.ram_sel,
					s_r.two_line, tall); // RULE3 RULE18
				if (bus.read_not_write) begin
					s_nxt.prefetch = 1'b1;
				end else begin
					mem_we = 1'b1;
					mem_data = in_byte; // RULE19
					if (s_r.follow_shift & (s_r.ram_sel == lcd_pkg::RAM_DISPLAY)) begin
						s_nxt.shift = shift_by(s_r.shift, s_r.inc); // RULE4
					end
				end
			end else if (byte_done & ~busy & ~bus.read_not_write) begin // RULE17
				s_nxt.busy_cnt = lcd_pkg::BUSY_W'(lcd_pkg::SHORT_OP_CYCLES);
				if (in_byte[7]) begin
					s_nxt.address_counter = in_byte[6:0]; // RULE15
					s_nxt.ram_sel = lcd_pkg::RAM_DISPLAY;
					s_nxt.prefetch = 1'b1;
				end else if (in_byte[6]) begin
					if (~s_r.table_page_select) begin
						s_nxt.address_counter = {1'b0, in_byte[5:0]}; // RULE14
						s_nxt.ram_sel = lcd_pkg::RAM_GLYPH;
						s_nxt.prefetch = 1'b1;
					end else if (in_byte[5:4] == 2'b00) begin
						s_nxt.address_counter = {3'b000, in_byte[3:0]}; // RULE22
						s_nxt.ram_sel = lcd_pkg::RAM_SYMBOL;
						s_nxt.prefetch = 1'b1;
					end
				end else if (in_byte[5]) begin
					s_nxt.bus_width_select = in_byte[4]; // RULE10
					s_nxt.two_line = in_byte[3];
					s_nxt.tall_font_select = in_byte[2]; // RULE11
					s_nxt.table_page_select = in_byte[0]; // RULE13
				end else if (in_byte[4]) begin
					if (s_r.table_page_select) begin
						if (~(s_r.strap_sync[1] & s_r.strap_sync[2])) begin
							s_nxt.bias_ratio_select = in_byte[3]; // RULE21
						end
					end else if (in_byte[3]) begin
						s_nxt.shift = shift_by(s_r.shift, ~in_byte[2]); // RULE8 RULE9
					end else begin
						s_nxt.address_counter = step_ac(s_r.address_counter, in_byte[2],
							s_r.ram_sel, s_r.two_line, tall); // RULE8
					end
				end else if (in_byte[3]) begin
					s_nxt.disp_on = in_byte[2]; // RULE5
					s_nxt.cursor_on = in_byte[1]; // RULE6
					s_nxt.blink_on = in_byte[0]; // RULE7
				end else if (in_byte[2]) begin
					s_nxt.inc = in_byte[1];
					s_nxt.follow_shift = in_byte[0];
				end else if (in_byte[1] | in_byte[0]) begin
					s_nxt.busy_cnt = lcd_pkg::BUSY_W'(LONG_CYCLES);
					s_nxt.address_counter = lcd_pkg::AC_HOME; // RULE2
					s_nxt.ram_sel = lcd_pkg::RAM_DISPLAY;
					s_nxt.shift = 6'h00;
					if (~in_byte[1]) begin
						s_nxt.clearing = 1'b1; // RULE1
						s_nxt.clr_idx = 7'h00;
						s_nxt.inc = 1'b1;
					end
				end else begin
					s_nxt.busy_cnt = '0;
				end
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s_r <= '0;
			s_r.inc <= lcd_pkg::RST_INC;
			s_r.bus_width_select <= lcd_pkg::RST_BUS_WIDTH;
		end else if (ce_i) begin
			s_r <= s_nxt;
		end
	end

	// RAM contents survive reset, as a real panel's would
	always_ff @(posedge clk_i) begin
		if (ce_i & mem_we) begin
			unique case (mem_sel)
				lcd_pkg::RAM_GLYPH: glyph_pattern_ram[mem_addr[5:0]] <= mem_data;
				lcd_pkg::RAM_SYMBOL: symbol_ram[mem_addr[3:0]] <= mem_data;
				default: char_display_ram[mem_addr] <= mem_data;
			endcase
		end
	end

	assign bus.dev_d = s_r.dev_d;
	assign bus.dev_d_oe = s_r.dev_d_oe;
	assign scan_char_o = s_r.scan_char;
	assign display_on_o = s_r.disp_on; // RULE5
	assign cursor_on_o = s_r.cursor_on & s_r.disp_on; // RULE6
	assign blink_full_o = s_r.blink_on & s_r.blink_phase & s_r.disp_on; // RULE7
	assign cursor_addr_o = s_r.address_counter;
	assign display_shift_o = s_r.shift;
	assign two_line_o = s_r.two_line;
	assign tall_font_o = s_r.tall_font_select & ~s_r.two_line & ~s_r.strap_sync[0];
	assign quarter_bias_o = s_r.bias_ratio_select;
	assign op_in_progress_o = (s_r.busy_cnt != '0);
endmodule
`default_nettype wire

// ===== char_lcd_instruction_engine_tb.sv
// Bench: software port drives the host controller, which drives the engine.
// Assumes one 100 MHz clock; long busy and blink counts are shortened.
`default_nettype none
module char_lcd_instruction_engine_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_i, rst_i, we_i, re_i, chk, opt, fa, fb, seen;
	logic mon = 1'b0;
	logic [4:0] addr_i;
	logic [31:0] wdata_i, rdata_o, v;
	logic [7:0] b, scan_char;
	logic [6:0] scan_addr, cur_addr;
	logic [5:0] dshift;
	logic disp_on, cur_on, blink, two, tall, qbias, busy;
	logic [7:0] wl[$];
	logic [31:0] exp_q[$];
	logic [7:0] dc[4] = '{8'h0f, 8'h0e, 8'h0b, 8'h0d};
	int n_fail, comparisons, seed;
	lcd_bus_if bus();
	char_lcd_instruction_engine #(.LONG_CYCLES(300), .BLINK_HALF_CYCLES(20))
		u_char_lcd_instruction_engine (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .bus(bus),
		.option_set_strap_i(opt), .follower_strap_a_i(fa), .follower_strap_b_i(fb),
		.scan_addr_i(scan_addr), .scan_char_o(scan_char), .display_on_o(disp_on),
		.cursor_on_o(cur_on), .blink_full_o(blink), .cursor_addr_o(cur_addr),
		.display_shift_o(dshift), .two_line_o(two), .tall_font_o(tall),
		.quarter_bias_o(qbias), .op_in_progress_o(busy));
	char_lcd_host u_char_lcd_host (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .addr_i(addr_i),
		.wdata_i(wdata_i), .we_i(we_i), .re_i(re_i), .rdata_o(rdata_o), .bus(bus));
	lcd_bus_chk u_lcd_bus_chk (.clk_i(clk_i), .rst_i(rst_i), .strobe(bus.strobe),
		.reg_select_line(bus.reg_select_line), .read_not_write(bus.read_not_write),
		.host_d(bus.host_d), .host_d_oe(bus.host_d_oe), .dev_d(bus.dev_d),
		.dev_d_oe(bus.dev_d_oe));
	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end
	task automatic end_sim;
		$display("comparisons %0d, mismatches %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			n_fail++;
			$display("unexpected %s: expected %h, seen %h", nm, e, g);
		end
	endtask
	// One port access; read data land in the cycle after the strobe
	task automatic sw(input logic [4:0] a, input logic [31:0] w, input logic wr, input logic c);
		addr_i <= a;
		wdata_i <= w;
		we_i <= wr;
		re_i <= !wr;
		chk <= c;
		@(posedge clk_i);
		we_i <= 1'b0;
		re_i <= 1'b0;
		chk <= 1'b0;
		#1 v = rdata_o;
		@(posedge clk_i);
	endtask
	// Bounded poll: a stuck controller must not hang the run
	task automatic xfer(input logic rs, input logic rd, input logic [7:0] by);
		int k;
		k = 0;
		sw(rd ? lcd_pkg::REG_READ_XFER : lcd_pkg::REG_WRITE_XFER, {23'h0, rs, by}, 1'b1, 1'b0);
		do begin
			sw(lcd_pkg::REG_STATUS, 32'h0, 1'b0, 1'b0);
			k++;
		end while (v[0] !== 1'b0 && k < 3000);
		check("transfer end", 1'b0, v[0]);
	endtask
	task automatic rdx(input logic rs, input logic [7:0] e);
		xfer(rs, 1'b1, 8'h00);
		exp_q.push_back({24'h0, e});
		sw(lcd_pkg::REG_RX_DATA, 32'h0, 1'b0, 1'b1);
	endtask
	task automatic scan(input logic [6:0] a, input logic [7:0] e);
		scan_addr <= a;
		repeat (3) @(posedge clk_i);
		check("panel char", e, scan_char);
	endtask
	always @(posedge clk_i) begin
		if (mon) begin
			check("read data", exp_q.pop_front(), rdata_o);
		end
		mon = re_i && chk;
	end
	always @(posedge clk_i) begin
		if (bus.host_d_oe) begin
			wl.push_back(bus.host_d);
		end
	end
	initial begin
		// Tests need about 88000 cycles, almost all of it busy waits
		repeat (99000) @(posedge clk_i);
		n_fail++;
		$display("unexpected run length: expected end, seen timeout");
		end_sim();
	end
	initial begin
		seed = 32'h5b9fb02b;
		n_fail = 0;
		comparisons = 0;
		{rst_i, we_i, re_i, chk, opt, fa, fb} = 7'h40;
		addr_i = 5'h00;
		wdata_i = 32'h0;
		scan_addr = 7'h00;
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		check("idle state", 32'h0, {busy, cur_addr, disp_on, two});
		b = 8'($random(seed));
		xfer(0, 0, 8'h85);
		xfer(1, 0, b);
		check("counter", 7'h06, cur_addr);
		scan(7'h05, b);
		xfer(0, 0, 8'h85);
		rdx(1, b);
		rdx(0, 8'h06);
		b = 8'($random(seed));
		xfer(0, 0, 8'h05);
		xfer(0, 0, 8'h8a);
		xfer(1, 0, b);
		check("counter down", 7'h09, cur_addr);
		check("shift", 6'd39, dshift);
		xfer(0, 0, 8'h8a);
		rdx(1, b);
		check("shift after read", 6'd39, dshift);
		xfer(0, 0, 8'h04);
		xfer(0, 0, 8'h02);
		check("home", 13'h0, {cur_addr, dshift});
		scan(7'h0a, b);
		xfer(0, 0, 8'h01);
		xfer(1, 0, b);
		check("clear entry", 7'h01, cur_addr);
		scan(7'h0a, lcd_pkg::SPACE_CODE);
		for (int i = 0; i < 4; i++) begin
			xfer(0, 0, 8'h10 + 8'(4 * i));
			check("move counter", (i == 0) ? 7'h00 : 7'h01, cur_addr);
			check("move shift", (i == 2) ? 6'd1 : 6'd0, dshift);
		end
		xfer(0, 0, 8'h7e);
		xfer(1, 0, b);
		check("glyph counter", 7'h3f, cur_addr);
		scan(7'h3e, lcd_pkg::SPACE_CODE);
		xfer(0, 0, 8'h38);
		xfer(0, 0, 8'ha7);
		xfer(1, 0, b);
		check("line wrap", 8'hc0, {two, cur_addr});
		for (int i = 0; i < 4; i++) begin
			xfer(0, 0, dc[i]);
			check("display on", dc[i][2], disp_on);
			check("cursor on", dc[i][2] & dc[i][1], cur_on);
			seen = 1'b0;
			repeat (45) begin
				@(posedge clk_i);
				seen = seen | blink;
			end
			check("blink", dc[i][2] & dc[i][0], seen);
		end
		xfer(0, 0, 8'h34);
		check("tall font", 1'b1, tall);
		opt <= 1'b1;
		repeat (4) @(posedge clk_i);
		check("strap font", 1'b0, tall);
		opt <= 1'b0;
		xfer(0, 0, 8'h39);
		xfer(0, 0, 8'h1c);
		check("bias", 7'h40, {qbias, dshift});
		{fa, fb} <= 2'b11;
		repeat (4) @(posedge clk_i);
		xfer(0, 0, 8'h10);
		check("bias kept", 1'b1, qbias);
		{fa, fb} <= 2'b00;
		xfer(0, 0, 8'h45);
		rdx(0, 8'h05);
		xfer(0, 0, 8'h28);
		sw(lcd_pkg::REG_STATUS, 32'h0, 1'b0, 1'b0);
		check("four-bit", 2'b01, v[2:1]);
		xfer(0, 0, 8'h83);
		wl.delete();
		b = 8'($random(seed));
		xfer(1, 0, b);
		check("nibble count", 2, wl.size());
		check("nibbles", {b[7:4], 4'h0, b[3:0], 4'h0}, {wl[0], wl[1]});
		rdx(1, lcd_pkg::SPACE_CODE);
		end_sim();
	end
endmodule
`default_nettype wire

// ===== lcd_bus_chk.sv
// Assertions on the host bus joining the controller and the display engine.
// Assumes both ends share clk_i and a synchronous active-high rst_i.
`default_nettype none
module lcd_bus_chk (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Bus signals
	input wire logic strobe,
	input wire logic reg_select_line,
	input wire logic read_not_write,
	input wire logic [7:0] host_d,
	input wire logic host_d_oe,
	input wire logic [7:0] dev_d,
	input wire logic dev_d_oe
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	logic st_rd;
	logic ins_pend_r;
	logic dw_pend_r;
	logic [7:0] last_ins_r;
	assign st_rd = strobe && read_not_write && !reg_select_line;
	// Only the first read after a write may judge that write
	always_ff @(posedge clk_i) begin
		if (rst_i || (strobe && read_not_write)) begin
			ins_pend_r <= 1'b0;
			dw_pend_r <= 1'b0;
		end else if (host_d_oe) begin
			ins_pend_r <= !reg_select_line;
			dw_pend_r <= reg_select_line;
		end
		if (host_d_oe && !reg_select_line) begin
			last_ins_r <= host_d;
		end
	end
	property p_rd_answer;
		strobe && read_not_write |=> $rose(dev_d_oe);
	endproperty
	a_rd_answer: assert property (p_rd_answer) else $error("read not answered");
	property p_oe_cause;
		dev_d_oe |-> $past(strobe && read_not_write);
	endproperty
	a_oe_cause: assert property (p_oe_cause) else $error("stray device drive");
	property p_wr_drive;
		host_d_oe == (strobe && !read_not_write);
	endproperty
	a_wr_drive: assert property (p_wr_drive) else $error("host drive mismatch");
	property p_strobe_gap;
		strobe |=> !strobe;
	endproperty
	a_strobe_gap: assert property (p_strobe_gap) else $error("strobes too close");
	property p_oe_single;
		dev_d_oe |=> !dev_d_oe;
	endproperty
	a_oe_single: assert property (p_oe_single) else $error("device drive too long");
	property p_test_bit;
		host_d_oe && !reg_select_line && host_d[7:5] == 3'b001 |-> !host_d[1];
	endproperty
	a_test_bit: assert property (p_test_bit) else $error("test bit set");
	property p_busy_seen;
		st_rd && dw_pend_r |=> dev_d_oe && dev_d[7];
	endproperty
	a_busy_seen: assert property (p_busy_seen) else $error("busy missing");
	property p_home_ac;
		st_rd && ins_pend_r && last_ins_r inside {8'h01, 8'h02, 8'h03} |=> dev_d[6:0] == 7'h00;
	endproperty
	a_home_ac: assert property (p_home_ac) else $error("counter not home");
	c_data_write: cover property (strobe && reg_select_line && !read_not_write);
	c_data_read: cover property (strobe && reg_select_line && read_not_write);
	c_busy: cover property (dev_d_oe && dev_d[7]);
endmodule
`default_nettype wire

// ===== lcd_bus_if.sv
// Parallel host bus between controller and display engine.
// Resolves the shared data lines from the two output enables.
`default_nettype none
interface lcd_bus_if;
	logic strobe;
	logic reg_select_line;
	logic read_not_write;
	logic [7:0] host_d;
	logic host_d_oe;
	logic [7:0] dev_d;
	logic dev_d_oe;
	logic [7:0] d;
	assign d = dev_d_oe ? dev_d : (host_d_oe ? host_d : 8'h00);
	modport device (input strobe, reg_select_line, read_not_write, d,
		output dev_d, dev_d_oe);
	modport host (output strobe, reg_select_line, read_not_write, host_d, host_d_oe,
		input d);
endinterface
`default_nettype wire

// ===== lcd_pkg.sv
// Shared constants for the character display instruction engine and its host.
// Assumes a single 100 MHz clock shared by both ends.
`default_nettype none
package lcd_pkg;
	localparam real CLK_PERIOD_NS = 10.0;
	localparam real SHORT_OP_US = 26.3;
	localparam real LONG_OP_MS = 1.08;
	localparam int SHORT_OP_CYCLES = int'($ceil(SHORT_OP_US * 1000.0 / CLK_PERIOD_NS));
	localparam int LONG_OP_CYCLES = int'($ceil(LONG_OP_MS * 1000000.0 / CLK_PERIOD_NS));
	localparam int BLINK_MS = 400;
	localparam int BLINK_CYCLES = int'(BLINK_MS * 1000000 / 10);
	localparam int BUSY_W = 17;
	localparam int BLINK_W = 26;
	// Address map of character display RAM
	localparam logic [6:0] DD_LINE1_END = 7'h27;
	localparam logic [6:0] DD_LINE2_START = 7'h40;
	localparam logic [6:0] DD_LINE2_END = 7'h67;
	localparam logic [6:0] DD_ONE_LINE_END = 7'h4f;
	localparam logic [5:0] SHIFT_SPAN = 6'h28;
	localparam logic [7:0] SPACE_CODE = 8'h20;
	localparam logic [6:0] AC_HOME = 7'h00;
	// Power-on settings of the device
	localparam logic RST_BUS_WIDTH = 1'b1;
	localparam logic RST_INC = 1'b1;
	// Host register map, byte addresses
	localparam logic [4:0] REG_WRITE_XFER = 5'h00;
	localparam logic [4:0] REG_READ_XFER = 5'h04;
	localparam logic [4:0] REG_STATUS = 5'h08;
	localparam logic [4:0] REG_RX_DATA = 5'h0c;
	localparam int XFER_RS_BIT = 8;
	typedef enum logic [1:0] {RAM_DISPLAY, RAM_GLYPH, RAM_SYMBOL} ram_sel_type;
endpackage
`default_nettype wire
